/* design/oesb_pkg.sv */
// package: constants, register map and carrier types of the output enable / side-band control block
package oesb_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// register offsets (byte addresses, one word each)
	localparam logic [ADDR_W-1:0] REG_SMB_ENABLE = 4'h0;
	localparam logic [ADDR_W-1:0] REG_GROUP_ASSIGN = 4'h4;
	localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;
	// sideband, irq and output-state registers sit in the lower half of the map, between the word offsets
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'h2;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 4'h3;
	localparam logic [ADDR_W-1:0] REG_OUT_STATE = 4'h5;
	localparam logic [ADDR_W-1:0] REG_SIDE_CTRL = 4'h6;
	// config register fields
	localparam int CFG_WP_BIT = 0;
	localparam int CFG_SLEW_OVR_BIT = 1;
	localparam int CFG_SLEW_VAL_BIT = 2;
	// irq bit positions
	localparam int IRQ_LOSS = 0;
	localparam int IRQ_LOAD = 1;
	localparam int IRQ_PWRDN = 2;
	localparam int IRQ_W = 3;
	// tri-level strap encoding
	localparam logic [1:0] TRI_LOW = 2'h0;
	localparam logic [1:0] TRI_MID = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h2;
	localparam logic [6:0] SMB_ADDR_BASE = 7'h68; // arbitrary neutral base
	// loss detector: no reference edge for this many ns (LOSS_TIMEOUT_CYC system cycles) means loss
	localparam int LOSS_TIMEOUT_NS = 1000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int LOSS_TIMEOUT_CYC = LOSS_TIMEOUT_NS / CLK_PERIOD_NS;
	typedef enum {PS_WAIT_FIRST, PS_RUN, PS_PWRDN} oesb_pwr_t;
	typedef struct packed {
		logic sideClk;
		logic sideData;
		logic shiftLoadN;
	} oesb_side_t;
	typedef struct packed {
		logic writeProtect;
		logic slewOverride;
		logic slewValue;
	} oesb_cfg_t;
endpackage

/* design/oesb_output_enable_sideband_ctrl.sv */
// output enable, side-band serial port, power sequencing and loss-of-signal control
//Contract
//- per-output enable pins are active low; 0 enables, 1 disables
//- mode strap 0 keeps shared pins as enables; 1 makes them side-band pins
//- in side-band mode register enables and unshared pins still apply
//- side-band data shifts in on each rising side-band clock edge
//- shared data pin is the shift register serial input
//- shift-load low freezes the shift register; high allows shifting
//- falling shift-load edge copies shift register into output control register
//- serial out drives shift register last bit for daisy chaining
//- first power-good high samples latched straps then starts up
//- later power-good low enters power-down; high leaves it
//- open-drain loss flag pulled low while reference clock is lost
//- outputs parked static while the reference clock is lost
//- four active-low group enables gate outputs per assignment registers
//- slave address decoded from tri-level straps taken together
//- straps select one of 9 addresses; write protect blocks register writes (here only enable and group-assign writes; config and irq writes pass)
//- slew rate comes from a strap or a register setting
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module oesb_output_enable_sideband_ctrl #(
	parameter int NUM_OUT = 24,
	parameter int IDX_SIDE_CLK = 23,
	parameter int IDX_SIDE_DATA = 22,
	parameter int IDX_SHIFT_LOAD = 2,
	parameter bit SIDE_MSB_FIRST = 1'b1
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [NUM_OUT-1:0] outEnableN, // per-output enable pins, active low; some shared
	input wire logic [3:0] groupEnableN, // group a..d enable pins, active low
	input wire logic sidebandModeStrap, // side-band select strap
	input wire logic powerGoodPowerdownN, // power-good / power-down pin
	input wire logic referenceClockIn, // reference clock activity
	input wire logic [1:0] slaveAddrStrap0, // tri-level strap 0 (low/mid/high)
	input wire logic [1:0] slaveAddrStrap1, // tri-level strap 1
	input wire logic slewStrap, // slew rate strap
	input wire logic [oesb_pkg::ADDR_W-1:0] regAddr, // register address
	input wire logic [oesb_pkg::DATA_W-1:0] regWdata, // register write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [oesb_pkg::DATA_W-1:0] regRdata, // read data, cycle after strobe
	output logic [NUM_OUT-1:0] clockOutEnable, // enable per clock output, active high
	output logic outputsParked, // outputs parked static
	output logic powerDown, // device in power-down
	output logic sidebandSerialOut, // side-band serial out
	output logic inputLossFlagNOut, // loss flag drive value (always 0)
	output logic inputLossFlagNOe, // loss flag drive enable, high pulls low
	output logic [6:0] slaveAddr, // decoded smbus address
	output logic slewSelect, // effective slew setting
	output logic irq // level interrupt
);
	localparam int LOSS_CNT_W = $clog2(oesb_pkg::LOSS_TIMEOUT_CYC + 1);
	localparam int DATA_W = oesb_pkg::DATA_W;

	// enables must fit one register word; the three shared pins must be distinct outputs
	if (NUM_OUT < 4 || NUM_OUT > DATA_W || IDX_SIDE_CLK >= NUM_OUT || IDX_SIDE_DATA >= NUM_OUT ||
		IDX_SHIFT_LOAD >= NUM_OUT)
	begin : gen_bad_size
		$error("oesb: unsupported parameters");
	end
	if (IDX_SIDE_CLK == IDX_SIDE_DATA || IDX_SIDE_CLK == IDX_SHIFT_LOAD || IDX_SIDE_DATA == IDX_SHIFT_LOAD)
	begin : gen_bad_share
		$error("oesb: shared pin indices overlap");
	end

	// three-stage input synchronisers; stage 0 feeds only stage 1
	localparam int SYNC_W = NUM_OUT + 4 + 3;
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] sync0, sync1, sync2;
	logic [SYNC_W-1:0] next_sync0, next_sync1, next_sync2;
	logic [SYNC_W-1:0] stable, next_stable;
	assign syncIn = {referenceClockIn, powerGoodPowerdownN, sidebandModeStrap, groupEnableN, outEnableN};

	always_comb
	begin
		next_sync0 = syncIn;
		next_sync1 = sync0;
		next_sync2 = sync1;
		// a change counts once stages two and three agree
		next_stable = stable;
		for (int i = 0; i < SYNC_W; i++)
			if (sync1[i] == sync2[i])
				next_stable[i] = sync2[i];
	end

	logic [NUM_OUT-1:0] pinEnN;
	logic [3:0] grpEnN;
	logic modeLive, pgood, refLive;
	assign pinEnN = stable[NUM_OUT-1:0];
	assign grpEnN = stable[NUM_OUT+3:NUM_OUT];
	assign modeLive = stable[NUM_OUT+4];
	assign pgood = stable[NUM_OUT+5];
	assign refLive = stable[NUM_OUT+6];

	// power sequencing and strap capture
	oesb_pkg::oesb_pwr_t pwrState, next_pwrState;
	logic sideMode, next_sideMode;
	logic [6:0] next_slaveAddr;
	logic strapSlew, next_strapSlew;

	function automatic logic [3:0] triDecode(input logic [1:0] s1, input logic [1:0] s0);
		logic [3:0] a1, a0;
		a1 = (s1 == oesb_pkg::TRI_HIGH) ? 4'h2 : (s1 == oesb_pkg::TRI_MID) ? 4'h1 : 4'h0;
		a0 = (s0 == oesb_pkg::TRI_HIGH) ? 4'h2 : (s0 == oesb_pkg::TRI_MID) ? 4'h1 : 4'h0;
		return 4'((a1 * 4'h3) + a0);
	endfunction

	always_comb
	begin
		next_pwrState = pwrState;
		next_sideMode = sideMode;
		next_slaveAddr = slaveAddr;
		next_strapSlew = strapSlew;
		case (pwrState)
			oesb_pkg::PS_WAIT_FIRST:
				if (pgood)
				begin
					// straps are caught once; later changes are ignored
					next_sideMode = modeLive;
					next_slaveAddr = oesb_pkg::SMB_ADDR_BASE + {3'h0, triDecode(slaveAddrStrap1, slaveAddrStrap0)};
					next_strapSlew = slewStrap;
					next_pwrState = oesb_pkg::PS_RUN;
				end
			oesb_pkg::PS_RUN:
				if (!pgood)
					next_pwrState = oesb_pkg::PS_PWRDN;
			oesb_pkg::PS_PWRDN:
				if (pgood)
					next_pwrState = oesb_pkg::PS_RUN;
			default:
				next_pwrState = oesb_pkg::PS_WAIT_FIRST;
		endcase
	end

	// loss of reference: no edge within the timeout
	logic refPrev, next_refPrev;
	logic [LOSS_CNT_W-1:0] lossCnt, next_lossCnt;
	logic lost, next_lost;
	always_comb
	begin
		next_refPrev = refLive;
		next_lossCnt = lossCnt;
		next_lost = lost;
		if (refLive != refPrev)
		begin
			next_lossCnt = '0;
			next_lost = 1'b0;
		end
		else if (lossCnt == LOSS_CNT_W'(oesb_pkg::LOSS_TIMEOUT_CYC))
			next_lost = 1'b1;
		else
			next_lossCnt = lossCnt + 1'b1;
	end

	// side-band serial port, sampled by edge detection on the system clock
	logic sclkPrev, next_sclkPrev;
	logic loadPrev, next_loadPrev;
	logic [NUM_OUT-1:0] shiftReg, next_shiftReg;
	logic [NUM_OUT-1:0] sideCtrl, next_sideCtrl;
	logic loadEvent;
	oesb_pkg::oesb_side_t side;
	assign side = '{sideClk: pinEnN[IDX_SIDE_CLK], sideData: pinEnN[IDX_SIDE_DATA],
		shiftLoadN: pinEnN[IDX_SHIFT_LOAD]};

	always_comb
	begin
		next_sclkPrev = side.sideClk;
		next_loadPrev = side.shiftLoadN;
		next_shiftReg = shiftReg;
		next_sideCtrl = sideCtrl;
		loadEvent = 1'b0;
		if (sideMode)
		begin
			if (side.sideClk && !sclkPrev && side.shiftLoadN)
			begin
				if (SIDE_MSB_FIRST)
					next_shiftReg = {shiftReg[NUM_OUT-2:0], side.sideData};
				else
					next_shiftReg = {side.sideData, shiftReg[NUM_OUT-1:1]};
			end
			if (!side.shiftLoadN && loadPrev)
			begin
				next_sideCtrl = shiftReg;
				loadEvent = 1'b1;
			end
		end
	end

	// register file
	logic [NUM_OUT-1:0] smbEnable, next_smbEnable;
	logic [7:0] groupAssign [NUM_OUT];
	logic [7:0] next_groupAssign [NUM_OUT];
	oesb_pkg::oesb_cfg_t cfg, next_cfg;
	logic [oesb_pkg::IRQ_W-1:0] irqStatus, next_irqStatus, irqEnable, next_irqEnable, irqEvent;
	logic [oesb_pkg::DATA_W-1:0] next_regRdata;
	logic wrOk;
	assign wrOk = regWr && !cfg.writeProtect;
	assign irqEvent = {(pwrState == oesb_pkg::PS_RUN) && !pgood, loadEvent, next_lost && !lost};

	always_comb
	begin
		next_smbEnable = smbEnable;
		next_groupAssign = groupAssign;
		next_cfg = cfg;
		next_irqEnable = irqEnable;
		next_irqStatus = irqStatus;
		next_regRdata = '0;
		if (wrOk)
			case (regAddr)
				oesb_pkg::REG_SMB_ENABLE: next_smbEnable = regWdata[NUM_OUT-1:0];
				// eight group bits per output, one output per write, selected by bits [31:24]
				oesb_pkg::REG_GROUP_ASSIGN:
					for (int i = 0; i < NUM_OUT; i++)
						if (regWdata[31:24] == 8'(i))
							next_groupAssign[i] = regWdata[7:0];
				default:
					;
			endcase
		// protection bit itself stays writable so software can unlock
		if (regWr && regAddr == oesb_pkg::REG_CONFIG)
		begin
			next_cfg.writeProtect = regWdata[oesb_pkg::CFG_WP_BIT];
			next_cfg.slewOverride = regWdata[oesb_pkg::CFG_SLEW_OVR_BIT];
			next_cfg.slewValue = regWdata[oesb_pkg::CFG_SLEW_VAL_BIT];
		end
		if (regWr && regAddr == oesb_pkg::REG_IRQ_ENABLE)
			next_irqEnable = regWdata[oesb_pkg::IRQ_W-1:0];
		if (regWr && regAddr == oesb_pkg::REG_IRQ_CLEAR)
			next_irqStatus = irqStatus & ~regWdata[oesb_pkg::IRQ_W-1:0];
		// a set in the same cycle as its clear wins
		next_irqStatus = next_irqStatus | irqEvent;
		if (regRd)
			case (regAddr)
				oesb_pkg::REG_SMB_ENABLE: next_regRdata = DATA_W'(smbEnable);
				oesb_pkg::REG_CONFIG:
				begin
					next_regRdata[oesb_pkg::CFG_WP_BIT] = cfg.writeProtect;
					next_regRdata[oesb_pkg::CFG_SLEW_OVR_BIT] = cfg.slewOverride;
					next_regRdata[oesb_pkg::CFG_SLEW_VAL_BIT] = cfg.slewValue;
				end
				oesb_pkg::REG_STATUS: next_regRdata = DATA_W'({slaveAddr, sideMode, lost, powerDown});
				oesb_pkg::REG_IRQ_STATUS: next_regRdata = DATA_W'(irqStatus);
				oesb_pkg::REG_IRQ_ENABLE: next_regRdata = DATA_W'(irqEnable);
				oesb_pkg::REG_OUT_STATE: next_regRdata = DATA_W'(clockOutEnable);
				oesb_pkg::REG_SIDE_CTRL: next_regRdata = DATA_W'(sideCtrl);
				default: next_regRdata = '0;
			endcase
	end

	// output enable combination
	logic [NUM_OUT-1:0] next_clockOutEnable;
	logic [NUM_OUT-1:0] pinOk;
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++)
		begin : gen_out
			logic shared;
			logic grpOk;
			assign shared = (g == IDX_SIDE_CLK) || (g == IDX_SIDE_DATA) || (g == IDX_SHIFT_LOAD);
			// a shared pin in side-band mode no longer gates its output
			assign pinOk[g] = (sideMode && shared) ? sideCtrl[g] : !pinEnN[g];
			// bits [3:0] pick groups a..d; no bit means no group gating
			assign grpOk = &(~(groupAssign[g][3:0] & grpEnN));
			assign next_clockOutEnable[g] = pinOk[g] && smbEnable[g] && grpOk &&
				(pwrState == oesb_pkg::PS_RUN) && !next_lost;
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sync0 <= '0;
			sync1 <= '0;
			sync2 <= '0;
			stable <= '0;
		end
		else
		begin
			sync0 <= next_sync0;
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			stable <= next_stable;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pwrState <= oesb_pkg::PS_WAIT_FIRST;
			sideMode <= 1'b0;
			slaveAddr <= '0;
			strapSlew <= 1'b0;
		end
		else
		begin
			pwrState <= next_pwrState;
			sideMode <= next_sideMode;
			slaveAddr <= next_slaveAddr;
			strapSlew <= next_strapSlew;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			refPrev <= 1'b0;
			lossCnt <= '0;
			lost <= 1'b0;
		end
		else
		begin
			refPrev <= next_refPrev;
			lossCnt <= next_lossCnt;
			lost <= next_lost;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclkPrev <= 1'b0;
			loadPrev <= 1'b0;
			shiftReg <= '0;
			sideCtrl <= '0;
			sidebandSerialOut <= 1'b0;
		end
		else
		begin
			sclkPrev <= next_sclkPrev;
			loadPrev <= next_loadPrev;
			shiftReg <= next_shiftReg;
			sideCtrl <= next_sideCtrl;
			sidebandSerialOut <= SIDE_MSB_FIRST ? next_shiftReg[NUM_OUT-1] : next_shiftReg[0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			smbEnable <= '1;
			for (int i = 0; i < NUM_OUT; i++)
				groupAssign[i] <= '0;
			cfg <= '0;
			irqStatus <= '0;
			irqEnable <= '0;
			regRdata <= '0;
			irq <= 1'b0;
		end
		else
		begin
			smbEnable <= next_smbEnable;
			groupAssign <= next_groupAssign;
			cfg <= next_cfg;
			irqStatus <= next_irqStatus;
			irqEnable <= next_irqEnable;
			regRdata <= next_regRdata;
			irq <= |(next_irqStatus & next_irqEnable);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			clockOutEnable <= '0;
			outputsParked <= 1'b1;
			powerDown <= 1'b1;
			inputLossFlagNOe <= 1'b0;
			inputLossFlagNOut <= 1'b0;
			slewSelect <= 1'b0;
		end
		else
		begin
			clockOutEnable <= next_clockOutEnable;
			outputsParked <= next_lost;
			powerDown <= (next_pwrState != oesb_pkg::PS_RUN);
			inputLossFlagNOe <= next_lost;
			inputLossFlagNOut <= 1'b0;
			slewSelect <= next_cfg.slewOverride ? next_cfg.slewValue : next_strapSlew;
		end
	end
endmodule // oesb_output_enable_sideband_ctrl
`default_nettype wire

/* tb/oesb_output_enable_sideband_ctrl_sva.sv */
// concurrent checks on the ports of the output enable / side-band control block
`timescale 1ns/10ps
`default_nettype none
module oesb_output_enable_sideband_ctrl_sva #(
	parameter int NUM_OUT = 24
) (
	input wire logic clk, // clock
	input wire logic srst, // reset
	input wire logic [NUM_OUT-1:0] outEnableN, // enable pins
	input wire logic powerGoodPowerdownN, // power-good pin
	input wire logic referenceClockIn, // reference
	input wire logic [1:0] slaveAddrStrap0, // strap 0
	input wire logic [1:0] slaveAddrStrap1, // strap 1
	input wire logic [NUM_OUT-1:0] clockOutEnable, // enables
	input wire logic outputsParked, // parked
	input wire logic powerDown, // power-down
	input wire logic inputLossFlagNOut, // flag value
	input wire logic inputLossFlagNOe, // flag enable
	input wire logic [6:0] slaveAddr // address
);
	logic [5:0] stillCnt, next_stillCnt;
	logic refSeen;
	// cycles since the raw reference last moved, saturating
	always_comb
	begin
		next_stillCnt = stillCnt;
		if (referenceClockIn != refSeen)
			next_stillCnt = 6'h0;
		else if (stillCnt != 6'h3f)
			next_stillCnt = stillCnt + 6'h1;
	end
	always_ff @(posedge clk)
	begin
		refSeen <= referenceClockIn;
		stillCnt <= srst ? 6'h0 : next_stillCnt;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_pin_off;
		outEnableN[5] [*8];
	endsequence
	sequence s_pg_drop;
		$fell(powerGoodPowerdownN) && !powerDown;
	endsequence
	a_flag_value: assert property (inputLossFlagNOut == 1'b0) else $error("loss flag drives high");
	// margin over the 25-cycle detector plus input synchroniser
	a_loss_detect: assert property (stillCnt == 6'h28 && !powerDown |-> inputLossFlagNOe) else $error("loss missed");
	a_parked_off: assert property (outputsParked [*3] |-> clockOutEnable == '0) else $error("parked yet enabled");
	a_pd_off: assert property (powerDown [*3] |-> clockOutEnable == '0) else $error("powered down yet enabled");
	a_pg_down: assert property (s_pg_drop |-> ##[1:12] powerDown) else $error("no power-down");
	a_pg_up: assert property ($rose(powerGoodPowerdownN) |-> ##[1:12] !powerDown) else $error("no startup");
	a_pin_off: assert property (s_pin_off |-> !clockOutEnable[5]) else $error("disabled pin output on");
	a_addr_decode: assert property (!powerDown [*3] |-> slaveAddr == oesb_pkg::SMB_ADDR_BASE
		+ {5'h0, slaveAddrStrap1} * 7'h3 + {5'h0, slaveAddrStrap0}) else $error("bad address");
endmodule // oesb_output_enable_sideband_ctrl_sva
bind oesb_output_enable_sideband_ctrl oesb_output_enable_sideband_ctrl_sva #(.NUM_OUT(NUM_OUT)) sva_i (
	.clk(clk), .srst(srst), .outEnableN(outEnableN), .powerGoodPowerdownN(powerGoodPowerdownN),
	.referenceClockIn(referenceClockIn), .slaveAddrStrap0(slaveAddrStrap0), .slaveAddrStrap1(slaveAddrStrap1),
	.clockOutEnable(clockOutEnable), .outputsParked(outputsParked), .powerDown(powerDown),
	.inputLossFlagNOut(inputLossFlagNOut), .inputLossFlagNOe(inputLossFlagNOe), .slaveAddr(slaveAddr));
`default_nettype wire

/* tb/oesb_side_model.sv */
// behavioural system controller driving the side-band serial pins
`timescale 1ns/10ps
`default_nettype none
module oesb_side_model #(
	parameter int NUM_OUT = 24,
	parameter int HALF = 4
) (
	input wire logic clk, // system clock
	output var oesb_pkg::oesb_side_t side // side-band pins
);
	initial
		side = '0;
	// clock stands still low between frames; data falls to the pull-down level
	task automatic send(input logic [NUM_OUT-1:0] frame);
		@(posedge clk);
		side.shiftLoadN <= 1'b1;
		repeat (HALF) @(posedge clk);
		for (int i = NUM_OUT - 1; i >= 0; i--)
		begin
			side.sideData <= frame[i];
			repeat (HALF) @(posedge clk);
			side.sideClk <= 1'b1;
			repeat (HALF) @(posedge clk);
			side.sideClk <= 1'b0;
		end
		side.sideData <= 1'b0;
		repeat (HALF) @(posedge clk);
		side.shiftLoadN <= 1'b0;
	endtask
endmodule // oesb_side_model
`default_nettype wire

/* tb/tb_oesb_output_enable_sideband_ctrl.sv */
// self-checking bench for the output enable / side-band control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_oesb_output_enable_sideband_ctrl;
	logic clk, srst, sideMode, pg, refRun, regWr, regRd, irq, parked, pd, serOut, lossOut, lossOe, slew, slewPin;
	logic refDiv = 1'b0;
	logic refClk = 1'b0;
	logic [1:0] strap0, strap1;
	logic [23:0] pins, clockOutEnable;
	logic [3:0] groupEnableN, regAddr;
	logic [31:0] regWdata, regRdata;
	logic [6:0] slaveAddr;
	oesb_pkg::oesb_side_t side;
	int failures, nTests;
	wire logic [23:0] outEnableN = sideMode ? {side.sideClk, side.sideData, pins[21:3], side.shiftLoadN, pins[1:0]} : pins;
	oesb_output_enable_sideband_ctrl oesb_output_enable_sideband_ctrl_i (.clk(clk), .srst(srst), .outEnableN(outEnableN),
		.groupEnableN(groupEnableN), .sidebandModeStrap(sideMode), .powerGoodPowerdownN(pg), .referenceClockIn(refClk),
		.slaveAddrStrap0(strap0), .slaveAddrStrap1(strap1), .slewStrap(slewPin), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .clockOutEnable(clockOutEnable), .outputsParked(parked),
		.powerDown(pd), .sidebandSerialOut(serOut), .inputLossFlagNOut(lossOut), .inputLossFlagNOe(lossOe),
		.slaveAddr(slaveAddr), .slewSelect(slew), .irq(irq));
	oesb_side_model oesb_side_model_i (.clk(clk), .side(side));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		refDiv <= ~refDiv;
		if (refRun && refDiv)
			refClk <= ~refClk;
	end
	task automatic results;
		$display("comparisons %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic chkrd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		`CHK(regRdata, e);
	endtask
	// mode strap only ever moves under reset
	task automatic boot(input logic mode);
		pg <= 1'b0;
		srst <= 1'b1;
		sideMode <= mode;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK({pd, parked, clockOutEnable}, 26'h2000000);
		@(posedge clk);
		pg <= 1'b1;
		repeat (20) @(negedge clk);
	endtask
	task automatic settle(input logic [3:0] grp);
		@(posedge clk);
		groupEnableN <= grp;
		repeat (10) @(negedge clk);
	endtask
	initial
	begin
		{srst, sideMode, pg, regWr, regRd, regAddr, regWdata} = '0;
		{strap0, strap1, slewPin} = {2'h2, 2'h1, 1'b1};
		{failures, nTests} = '0;
		{refRun, groupEnableN, pins} = {1'b1, 4'h0, 24'h000020};
		boot(1'b0);
		`CHK({slaveAddr, slew, clockOutEnable}, 32'hdbffffdf);
		chkrd(oesb_pkg::REG_STATUS, 32'h368);
		chkrd(4'h7, 32'h0);
		wr(oesb_pkg::REG_CONFIG, 32'h2);
		repeat (4) @(negedge clk);
		`CHK(slew, 1'b0);
		wr(oesb_pkg::REG_SMB_ENABLE, 32'hfffffff7);
		wr(oesb_pkg::REG_GROUP_ASSIGN, 32'h07000002);
		wr(oesb_pkg::REG_CONFIG, 32'h1);
		chkrd(oesb_pkg::REG_CONFIG, 32'h1);
		wr(oesb_pkg::REG_SMB_ENABLE, 32'h0);
		wr(oesb_pkg::REG_GROUP_ASSIGN, 32'h07000000);
		settle(4'h2);
		`CHK(clockOutEnable, 24'hffff57);
		settle(4'hd);
		`CHK(clockOutEnable, 24'hffffd7);
		$display("test enables done");
		wr(oesb_pkg::REG_IRQ_ENABLE, 32'h1);
		@(posedge clk);
		refRun <= 1'b0;
		repeat (45) @(negedge clk);
		`CHK({parked, lossOe, lossOut, irq, clockOutEnable}, 28'hd000000);
		chkrd(oesb_pkg::REG_IRQ_STATUS, 32'h1);
		@(posedge clk);
		refRun <= 1'b1;
		repeat (12) @(negedge clk);
		wr(oesb_pkg::REG_IRQ_CLEAR, 32'h1);
		repeat (3) @(negedge clk);
		`CHK({parked, lossOe, irq}, 3'h0);
		$display("test loss done");
		@(posedge clk);
		pg <= 1'b0;
		repeat (12) @(negedge clk);
		`CHK({pd, clockOutEnable}, 25'h1000000);
		@(posedge clk);
		pg <= 1'b1;
		repeat (12) @(negedge clk);
		`CHK({pd, clockOutEnable}, 25'h0ffffd7);
		$display("test power done");
		@(posedge clk);
		{strap0, strap1, slewPin} <= {2'h0, 2'h2, 1'b0};
		boot(1'b1);
		`CHK({slaveAddr, slew}, 8'hdc);
		oesb_side_model_i.send(24'h800004);
		repeat (10) @(negedge clk);
		`CHK({serOut, clockOutEnable}, 25'h1bfffdf);
		oesb_side_model_i.send(24'h400000);
		repeat (10) @(negedge clk);
		`CHK({serOut, clockOutEnable}, 25'h07fffdb);
		chkrd(oesb_pkg::REG_SIDE_CTRL, 32'h400000);
		chkrd(oesb_pkg::REG_IRQ_STATUS, 32'h2);
		chkrd(oesb_pkg::REG_OUT_STATE, 32'h7fffdb);
		$display("test side-band done");
		results();
	end
	initial
	begin
		#(40 * 5000);
		failures++;
		results();
	end
endmodule // tb_oesb_output_enable_sideband_ctrl
`default_nettype wire
